// [rtl/usf_pkg.sv]
// usf_pkg: constants shared by the serial port status-flag block.
// assumes: included first in compile order; used by usf_top, usf_asserts and tb_top.
`default_nettype none

package usf_pkg;
  // receive word width (8 data bits plus optional ninth bit)
  localparam int WORD_W = 9;
  localparam int DATA_W = 8;
  localparam int RX_DEPTH = 4;

  // register select codes on the internal data bus
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_CTRL_ONE = 3'h1;
  localparam logic [2:0] SEL_CTRL_TWO = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h3;
  localparam logic [2:0] SEL_BAUD = 3'h4;

  // status_register bit positions
  localparam int ST_PARITY = 7;
  localparam int ST_NOISE = 6;
  localparam int ST_FRAME = 5;
  localparam int ST_OVERRUN = 4;
  localparam int ST_RX_IDLE = 3;
  localparam int ST_RX_AVAIL = 2;
  localparam int ST_TX_IDLE = 1;
  localparam int ST_TX_EMPTY = 0;

  // control_register_one bit positions
  localparam int C1_PORT_EN = 7;
  localparam int C1_NINE_BIT = 6;
  localparam int C1_PAR_EN = 5;
  localparam int C1_PAR_ODD = 4;
  localparam int C1_BREAK = 2;
  localparam int C1_RX8 = 1;
  localparam int C1_TX8 = 0;

  // control_register_two bit positions
  localparam int C2_TX_EN = 7;
  localparam int C2_RX_EN = 6;
  localparam int C2_RX_IE = 2;

  // reset values and masks
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [3:0] ERR_RST = 4'h0;
  localparam logic [7:0] ARM_RST = 8'h00;
  localparam logic [7:0] C1_OFF_MASK = 8'hFB; // break cleared when port is off
  localparam logic [7:0] C2_OFF_MASK = 8'h3F; // both enables cleared when port is off
  localparam logic [7:0] C1_RD_MASK = 8'hFC; // tx8 is write-only, rx8 is inserted
endpackage

`default_nettype wire

// [rtl/usf_stream_if.sv]
// usf_stream_if: valid/ready word carrier between the block's own modules.
// assumes: both ends share one clock; a word moves when valid and ready are high.
`default_nettype none

interface usf_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// [rtl/usf_fifo.sv]
// usf_fifo: receive data buffer, parameterised width and depth.
// assumes: synchronous flush; head word is visible on rd.data while rd.valid.
`default_nettype none

module usf_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic flush,
  usf_stream_if.snk wr,
  usf_stream_if.src rd,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pop;

  // pointer step with wrap, so depth need not be a power of two
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // honest flags: ready drops when full so the writer sees back-pressure
  assign wr.ready = (cnt_reg != CW'(DEPTH));
  assign rd.valid = (cnt_reg != '0);
  assign rd.data = mem[rptr_reg];
  assign level = cnt_reg;
  assign push = ce && wr.valid && wr.ready;
  assign pop = ce && rd.valid && rd.ready;

  // storage is not reset; rd.data shows mem[rptr_reg] even when empty, and the control-one read takes rx8 from it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= wr.data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      if (flush) begin
        wptr_reg <= '0;
        rptr_reg <= '0;
        cnt_reg <= '0;
      end else begin
        if (push) wptr_reg <= step(wptr_reg);
        if (pop) rptr_reg <= step(rptr_reg);
        if (push && !pop) cnt_reg <= CW'(cnt_reg + 1'b1);
        else if (pop && !push) cnt_reg <= CW'(cnt_reg - 1'b1);
      end
    end
  end
endmodule

`default_nettype wire

// [rtl/usf_tx_hold.sv]
// usf_tx_hold: one-word transmit data holding register toward the shifter.
// assumes: the shifter takes a word when out_valid and out_ready are both high.
`default_nettype none

module usf_tx_hold #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic flush,
  usf_stream_if.snk wr,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic taken
);
  logic full_reg;

  // a word may enter when empty or when the held one leaves this cycle
  assign wr.ready = !full_reg || out_ready;
  assign out_valid = full_reg;
  assign taken = ce && full_reg && out_ready && !flush;

  // held word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= '0;
    end else if (ce && wr.valid && wr.ready) begin
      out_data <= wr.data;
    end
  end

  // occupancy; flush aborts a queued word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_reg <= 1'b0;
    end else if (ce) begin
      if (flush) full_reg <= 1'b0;
      else if (wr.valid && wr.ready) full_reg <= 1'b1;
      else if (taken) full_reg <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// [rtl/usf_top.sv]
// usf_top: status flags, control registers and data buffering of a serial port.
// assumes: frame shifters, baud generator and pin drivers sit outside and
// report per-word events here; the register port is the internal data bus.
//
// Overview of operation
// - status register is read-only, writes ignored
// - parity flag bit 7, only when parity enabled
// - error flags clear on status read, data access
// - noise flag with data-available, never on overrun
// - framing flag bit 5 on badly framed word
// - overrun bit 4 blocks further received transfers
// - receiver idle bit 3 low start to stop
// - transfer sets data-available bit 2, interrupt
// - word errors flagged in transfer cycle
// - data-available clears after read, buffer empty
// - transmitter idle bit 1 when empty, quiet
// - transmitter idle clears on status read, write
// - transmitter idle never while word or break queued
// - transmit-empty bit 0 set when shifter takes
// - transmit-empty clears on status read, write
// - enabling transmitter sets transmit-empty flag
// - port off clears errors, sets idle, empty
`default_nettype none

module usf_top #(
  parameter int RX_DEPTH = usf_pkg::RX_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [2:0] REG_SEL,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic RX_WORD_VALID,
  input wire logic [usf_pkg::WORD_W-1:0] RX_WORD,
  input wire logic RX_PARITY_BIT,
  input wire logic RX_NOISE,
  input wire logic RX_FRAME_ERR,
  input wire logic RX_START,
  input wire logic RX_STOP_DONE,
  output logic TX_WORD_VALID,
  output logic [usf_pkg::WORD_W-1:0] TX_WORD,
  input wire logic TX_WORD_READY,
  input wire logic TX_SHIFT_BUSY,
  output logic RX_INT_REQ,
  output logic [7:0] CTRL_ONE_OUT,
  output logic [7:0] CTRL_TWO_OUT,
  output logic [7:0] BAUD_DIVISOR_OUT
);
  localparam int LW = $clog2(RX_DEPTH + 1);

  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic [7:0] baud_reg;
  logic [3:0] err_reg; // parity, noise, framing, overrun
  logic rx_idle_reg;
  logic rx_avail_reg;
  logic tx_idle_reg;
  logic tx_empty_reg;
  logic [7:0] arm_reg;
  logic [7:0] status_now;
  logic [LW-1:0] rx_level;
  logic rd_stb;
  logic wr_stb;
  logic stat_rd;
  logic data_rd;
  logic data_wr;
  logic data_acc;
  logic port_en;
  logic rx_on;
  logic tx_on;
  logic rx_push;
  logic ovr_evt;
  logic par_bad;
  logic tx_taken;
  logic tx_en_rise;
  logic [3:0] err_set;
  logic [3:0] err_clr;

  usf_stream_if #(.W(usf_pkg::WORD_W)) rx_in ();
  usf_stream_if #(.W(usf_pkg::WORD_W)) rx_out ();
  usf_stream_if #(.W(usf_pkg::WORD_W)) tx_wr ();

  // received parity check: even type wants an even count of ones
  function automatic logic parity_wrong(input logic [usf_pkg::WORD_W-1:0] w,
                                        input logic nine,
                                        input logic pbit,
                                        input logic odd);
    logic ones;
    ones = (nine ? (^w) : (^w[usf_pkg::DATA_W-1:0])) ^ pbit;
    parity_wrong = ones ^ odd;
  endfunction

  // bus strobes, frozen with the clock enable
  assign rd_stb = REG_RD && CE;
  assign wr_stb = REG_WR && CE;
  assign stat_rd = rd_stb && (REG_SEL == usf_pkg::SEL_STATUS);
  assign data_rd = rd_stb && (REG_SEL == usf_pkg::SEL_DATA);
  assign data_wr = wr_stb && (REG_SEL == usf_pkg::SEL_DATA);
  assign data_acc = data_rd || data_wr;

  assign port_en = ctrl_one_reg[usf_pkg::C1_PORT_EN];
  assign rx_on = port_en && ctrl_two_reg[usf_pkg::C2_RX_EN];
  assign tx_on = port_en && ctrl_two_reg[usf_pkg::C2_TX_EN];

  assign status_now = {err_reg, rx_idle_reg, rx_avail_reg, tx_idle_reg, tx_empty_reg};

  // receive path: words enter the buffer unless overrun is pending
  assign rx_in.valid = CE && rx_on && RX_WORD_VALID && !err_reg[0];
  assign rx_in.data = RX_WORD;
  assign rx_push = rx_in.valid && rx_in.ready;
  // a word that finds the buffer full, or overrun still set, is lost
  assign ovr_evt = CE && rx_on && RX_WORD_VALID && (!rx_in.ready || err_reg[0]);
  assign par_bad = ctrl_one_reg[usf_pkg::C1_PAR_EN] &&
                   parity_wrong(RX_WORD, ctrl_one_reg[usf_pkg::C1_NINE_BIT],
                                RX_PARITY_BIT, ctrl_one_reg[usf_pkg::C1_PAR_ODD]);

  // parity, noise and framing events only ride on a word that is actually transferred
  assign err_set = {rx_push && par_bad,
                    rx_push && RX_NOISE,
                    rx_push && RX_FRAME_ERR,
                    ovr_evt};
  assign err_clr = data_acc ? arm_reg[7:4] : 4'h0;

  // the data register is the buffer head; a data read pops it
  assign rx_out.ready = data_rd;
  assign RX_INT_REQ = rx_avail_reg && ctrl_two_reg[usf_pkg::C2_RX_IE];

  // transmit path: data writes queue into the holding register
  assign tx_wr.valid = data_wr && tx_on;
  assign tx_wr.data = {ctrl_one_reg[usf_pkg::C1_TX8], REG_WDATA};
  assign tx_en_rise = wr_stb && (REG_SEL == usf_pkg::SEL_CTRL_TWO) &&
                      REG_WDATA[usf_pkg::C2_TX_EN] && !ctrl_two_reg[usf_pkg::C2_TX_EN];

  assign CTRL_ONE_OUT = ctrl_one_reg;
  assign CTRL_TWO_OUT = ctrl_two_reg;
  assign BAUD_DIVISOR_OUT = baud_reg;

  usf_fifo #(
    .W(usf_pkg::WORD_W),
    .DEPTH(RX_DEPTH)
  ) u_rx_buf (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .ce(CE),
    .flush(!rx_on),
    .wr(rx_in),
    .rd(rx_out),
    .level(rx_level)
  );

  usf_tx_hold #(
    .W(usf_pkg::WORD_W)
  ) u_tx_hold (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .ce(CE),
    .flush(!tx_on),
    .wr(tx_wr),
    .out_valid(TX_WORD_VALID),
    .out_data(TX_WORD),
    .out_ready(TX_WORD_READY),
    .taken(tx_taken)
  );

  // control one: a write stores all 8 bits, break cleared if port bit is 0; a read shows rx8 in bit 1 and 0 in bit 0
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_one_reg <= usf_pkg::CTRL_RST;
    end else if (CE) begin
      if (wr_stb && REG_SEL == usf_pkg::SEL_CTRL_ONE) begin
        ctrl_one_reg <= REG_WDATA[usf_pkg::C1_PORT_EN] ? REG_WDATA
                        : (REG_WDATA & usf_pkg::C1_OFF_MASK);
      end else if (!port_en) begin
        ctrl_one_reg <= ctrl_one_reg & usf_pkg::C1_OFF_MASK;
      end
    end
  end

  // control two: both enables drop while the port is off
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_two_reg <= usf_pkg::CTRL_RST;
    end else if (CE) begin
      if (wr_stb && REG_SEL == usf_pkg::SEL_CTRL_TWO) begin
        ctrl_two_reg <= port_en ? REG_WDATA : (REG_WDATA & usf_pkg::C2_OFF_MASK);
      end else if (!port_en) begin
        ctrl_two_reg <= ctrl_two_reg & usf_pkg::C2_OFF_MASK;
      end
    end
  end

  // baud divisor is plain storage for the generator outside
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      baud_reg <= usf_pkg::BAUD_RST;
    end else if (wr_stb && REG_SEL == usf_pkg::SEL_BAUD) begin
      baud_reg <= REG_WDATA;
    end
  end

  // clear arming: a status read remembers which flags it saw set;
  // any data access consumes the arming so stale reads clear nothing
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      arm_reg <= usf_pkg::ARM_RST;
    end else if (CE) begin
      if (!port_en) arm_reg <= usf_pkg::ARM_RST;
      else if (stat_rd) arm_reg <= status_now;
      else if (data_acc) arm_reg <= usf_pkg::ARM_RST;
    end
  end

  // error flags: a new event wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      err_reg <= usf_pkg::ERR_RST;
    end else if (CE) begin
      if (!port_en) err_reg <= usf_pkg::ERR_RST;
      else err_reg <= (err_reg & ~err_clr) | err_set;
    end
  end

  // receiver idle follows the shifter's start and stop reports
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_idle_reg <= 1'b1;
    end else if (CE) begin
      if (!rx_on) rx_idle_reg <= 1'b1;
      else if (RX_START) rx_idle_reg <= 1'b0;
      else if (RX_STOP_DONE) rx_idle_reg <= 1'b1;
    end
  end

  // data available: set on transfer; cleared when the receiver is off, or by an armed read
  // that leaves the buffer empty, otherwise the next word keeps it up
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_avail_reg <= 1'b0;
    end else if (CE) begin
      if (!rx_on) rx_avail_reg <= 1'b0;
      else if (rx_push) rx_avail_reg <= 1'b1;
      else if (data_rd && arm_reg[usf_pkg::ST_RX_AVAIL] &&
               rx_level <= LW'(1)) rx_avail_reg <= 1'b0;
    end
  end

  // transmit empty: set on hand-off to the shifter or on enabling;
  // a set in the same cycle as an armed write wins
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tx_empty_reg <= 1'b1;
    end else if (CE) begin
      if (!port_en) tx_empty_reg <= 1'b1;
      else if (tx_taken || tx_en_rise) tx_empty_reg <= 1'b1;
      else if (data_wr && arm_reg[usf_pkg::ST_TX_EMPTY]) tx_empty_reg <= 1'b0;
    end
  end

  // transmit idle: needs an empty holding register, a quiet shifter
  // and no break request; a queued word or break holds it low
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tx_idle_reg <= 1'b1;
    end else if (CE) begin
      if (!port_en) begin
        tx_idle_reg <= 1'b1;
      end else if (tx_empty_reg && !TX_SHIFT_BUSY && !TX_WORD_VALID &&
                   !ctrl_one_reg[usf_pkg::C1_BREAK] && !tx_wr.valid) begin
        tx_idle_reg <= 1'b1;
      end else if (data_wr && arm_reg[usf_pkg::ST_TX_IDLE]) begin
        tx_idle_reg <= 1'b0;
      end else if (TX_WORD_VALID || ctrl_one_reg[usf_pkg::C1_BREAK]) begin
        tx_idle_reg <= 1'b0;
      end
    end
  end

  // read data is registered; status has no write path at all
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (rd_stb) begin
      case (REG_SEL)
        usf_pkg::SEL_STATUS: REG_RDATA <= status_now;
        usf_pkg::SEL_CTRL_ONE: begin
          REG_RDATA <= (ctrl_one_reg & usf_pkg::C1_RD_MASK) |
                       (8'(rx_out.data[usf_pkg::DATA_W]) << usf_pkg::C1_RX8);
        end
        usf_pkg::SEL_CTRL_TWO: REG_RDATA <= ctrl_two_reg;
        usf_pkg::SEL_DATA: REG_RDATA <= rx_out.valid ? rx_out.data[7:0] : 8'h00;
        usf_pkg::SEL_BAUD: REG_RDATA <= baud_reg;
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end
endmodule

`default_nettype wire

// [tb/usf_asserts.sv]
// usf_asserts: port-level checks of the status-flag block.
// assumes: bound to usf_top; one clock, async active-low reset.
`default_nettype none
module usf_asserts #(
  parameter int RX_DEPTH = 4
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [2:0] REG_SEL,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic RX_WORD_VALID,
  input wire logic TX_WORD_VALID,
  input wire logic [usf_pkg::WORD_W-1:0] TX_WORD,
  input wire logic TX_WORD_READY,
  input wire logic RX_INT_REQ,
  input wire logic [7:0] CTRL_ONE_OUT,
  input wire logic [7:0] CTRL_TWO_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  logic rx_on;
  logic tx_on;
  logic dwr;
  // enables as the outputs show them; the bus strobe only counts with CE
  assign rx_on = CE && CTRL_ONE_OUT[7] && CTRL_TWO_OUT[6];
  assign tx_on = CE && CTRL_ONE_OUT[7] && CTRL_TWO_OUT[7];
  assign dwr = CE && REG_WR && REG_SEL == usf_pkg::SEL_DATA;
  a_int_needs_ie:
    assert property (RX_INT_REQ |-> CTRL_TWO_OUT[2]) else $error("interrupt without enable");
  a_rx_sets_int:
    assert property (rx_on && RX_WORD_VALID && CTRL_TWO_OUT[2] && !REG_WR && !REG_RD
      |=> RX_INT_REQ) else $error("word did not raise interrupt");
  a_status_avail:
    assert property (CE && REG_RD && REG_SEL == usf_pkg::SEL_STATUS && CTRL_TWO_OUT[2]
      |=> REG_RDATA[usf_pkg::ST_RX_AVAIL] == $past(RX_INT_REQ)) else $error("avail bit wrong");
  a_off_ctrl:
    assert property ($fell(CTRL_ONE_OUT[7]) |-> ##[0:1] (CTRL_TWO_OUT[7:6] == 2'b00
      && !CTRL_ONE_OUT[2])) else $error("port off kept enables");
  a_off_int:
    assert property (!CTRL_ONE_OUT[7] ##1 !CTRL_ONE_OUT[7] |-> !RX_INT_REQ)
      else $error("interrupt while port off");
  a_tx_load:
    assert property (dwr && tx_on && !TX_WORD_VALID |=> TX_WORD_VALID
      && TX_WORD[7:0] == $past(REG_WDATA)) else $error("data write not queued");
  a_tx_hold:
    assert property (CE && TX_WORD_VALID && !TX_WORD_READY && !REG_WR |=> TX_WORD_VALID
      && $stable(TX_WORD)) else $error("queued word lost");
  a_tx_take:
    assert property (CE && TX_WORD_VALID && TX_WORD_READY && !dwr |=> !TX_WORD_VALID)
      else $error("taken word still queued");
  a_rdata_hold:
    assert property (CE && !REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  c_rx_word: cover property (rx_on && RX_WORD_VALID);
  c_tx_take: cover property (TX_WORD_VALID && TX_WORD_READY);
  c_port_off: cover property ($fell(CTRL_ONE_OUT[7]));
endmodule

bind usf_top usf_asserts #(.RX_DEPTH(RX_DEPTH)) u_usf_asserts (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .REG_SEL(REG_SEL), .REG_RD(REG_RD),
  .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .RX_WORD_VALID(RX_WORD_VALID), .TX_WORD_VALID(TX_WORD_VALID), .TX_WORD(TX_WORD),
  .TX_WORD_READY(TX_WORD_READY), .RX_INT_REQ(RX_INT_REQ),
  .CTRL_ONE_OUT(CTRL_ONE_OUT), .CTRL_TWO_OUT(CTRL_TWO_OUT)
);
`default_nettype wire

// [tb/usf_shift_model.sv]
// usf_shift_model: stand-in for the transmit shifter beyond the block.
// assumes: takes a word on valid and ready at a rising edge, then sends it.
`default_nettype none
module usf_shift_model #(
  parameter int WAIT_CYC = 6,
  parameter int LEN = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic valid,
  input wire logic [8:0] word,
  output logic ready,
  output logic busy,
  output logic [8:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  int wcnt;
  int bcnt;
  // busy while the frame is on the line
  assign busy = bcnt != 0;
  // slow acceptance, so the queued state is visible for several cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      got <= 9'h000;
      wcnt <= 0;
      bcnt <= 0;
    end else if (valid && ready) begin
      ready <= 1'b0;
      got <= word;
      wcnt <= 0;
      bcnt <= LEN;
    end else begin
      if (bcnt != 0) bcnt <= bcnt - 1;
      if (valid && bcnt == 0 && wcnt == WAIT_CYC) ready <= 1'b1;
      else if (valid && bcnt == 0) wcnt <= wcnt + 1;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// tb_top: self-checking bench for the serial port status-flag block.
// assumes: rtl/usf_* compiled first; usf_shift_model plays the shifter.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] S_ST = usf_pkg::SEL_STATUS;
  localparam logic [2:0] S_DA = usf_pkg::SEL_DATA;
  localparam logic [2:0] S_C1 = usf_pkg::SEL_CTRL_ONE;
  localparam logic [2:0] S_C2 = usf_pkg::SEL_CTRL_TWO;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic CE = 1'b1;
  logic [2:0] REG_SEL = 3'h0;
  logic REG_RD = 1'b0;
  logic REG_WR = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic [7:0] REG_RDATA;
  logic RX_WORD_VALID = 1'b0;
  logic [8:0] RX_WORD = 9'h000;
  logic RX_PARITY_BIT = 1'b0;
  logic RX_NOISE = 1'b0;
  logic RX_FRAME_ERR = 1'b0;
  logic RX_START = 1'b0;
  logic RX_STOP_DONE = 1'b0;
  logic TX_WORD_VALID;
  logic [8:0] TX_WORD;
  logic TX_WORD_READY;
  logic TX_SHIFT_BUSY;
  logic RX_INT_REQ;
  logic [7:0] CTRL_ONE_OUT;
  logic [7:0] CTRL_TWO_OUT;
  logic [7:0] BAUD_DIVISOR_OUT;
  logic [8:0] got;
  int fail_count = 0;
  int cmp_count = 0;
  usf_top DUT (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .REG_SEL(REG_SEL), .REG_RD(REG_RD),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .RX_WORD_VALID(RX_WORD_VALID), .RX_WORD(RX_WORD), .RX_PARITY_BIT(RX_PARITY_BIT),
    .RX_NOISE(RX_NOISE), .RX_FRAME_ERR(RX_FRAME_ERR), .RX_START(RX_START),
    .RX_STOP_DONE(RX_STOP_DONE), .TX_WORD_VALID(TX_WORD_VALID), .TX_WORD(TX_WORD),
    .TX_WORD_READY(TX_WORD_READY), .TX_SHIFT_BUSY(TX_SHIFT_BUSY), .RX_INT_REQ(RX_INT_REQ),
    .CTRL_ONE_OUT(CTRL_ONE_OUT), .CTRL_TWO_OUT(CTRL_TWO_OUT),
    .BAUD_DIVISOR_OUT(BAUD_DIVISOR_OUT)
  );
  usf_shift_model u_shift (
    .clk(CLK_SYS), .rst_n(RST_N), .valid(TX_WORD_VALID), .word(TX_WORD),
    .ready(TX_WORD_READY), .busy(TX_SHIFT_BUSY), .got(got)
  );
  // 25 MHz system clock
  initial forever #20 CLK_SYS = ~CLK_SYS;
  // every drive lands 2 ns after a rising edge
  task automatic tick();
    @(posedge CLK_SYS);
    #2;
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobes are one cycle; an idle edge follows so no strobe is set twice at once
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    REG_SEL = s;
    REG_WDATA = d;
    REG_WR = 1'b1;
    tick();
    REG_WR = 1'b0;
    tick();
  endtask
  // an empty name reads without comparing
  task automatic rd(input logic [2:0] s, input logic [7:0] exp, input string what);
    REG_SEL = s;
    REG_RD = 1'b1;
    tick();
    REG_RD = 1'b0;
    if (what != "") chk(what, exp, REG_RDATA);
    tick();
  endtask
  // e is {parity bit, noise, framing}; the word lines are scrambled once released
  task automatic rxw(input logic [8:0] w, input logic [2:0] e);
    RX_WORD = w;
    {RX_PARITY_BIT, RX_NOISE, RX_FRAME_ERR} = e;
    RX_WORD_VALID = 1'b1;
    tick();
    RX_WORD_VALID = 1'b0;
    RX_WORD = ~w;
    tick();
  endtask
  task automatic pulse(input logic st);
    RX_START = st;
    RX_STOP_DONE = !st;
    tick();
    RX_START = 1'b0;
    RX_STOP_DONE = 1'b0;
    tick();
  endtask
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 200 && TX_SHIFT_BUSY !== v; i++) tick();
    if (TX_SHIFT_BUSY !== v) begin
      fail_count++;
      $display("BAD shifter wait expected %b seen %b", v, TX_SHIFT_BUSY);
      wrap_up();
    end
  endtask
  initial begin
    repeat (6) @(posedge CLK_SYS);
    #2;
    RST_N = 1'b1;
    tick();
    rd(S_ST, 8'h0B, "status reset");
    wr(S_ST, 8'hFF);
    rd(S_ST, 8'h0B, "status written");
    rd(3'h5, 8'h00, "unmapped");
    wr(usf_pkg::SEL_BAUD, 8'h3C);
    rd(usf_pkg::SEL_BAUD, 8'h3C, "baud");
    chk("baud out", 8'h3C, BAUD_DIVISOR_OUT);
    // port on, even parity, ninth tx bit; tx, rx and rx interrupt on
    wr(S_C1, 8'hA1);
    wr(S_C2, 8'hC4);
    rd(S_ST, 8'h0B, "status on");
    // one word with parity, noise and framing faults: 0x01 plus parity 0 is odd under even parity
    rxw(9'h001, 3'b011);
    chk("rx int", 8'h01, {7'h00, RX_INT_REQ});
    rd(S_ST, 8'hEF, "errors");
    rd(S_DA, 8'h01, "data one");
    rd(S_ST, 8'h0B, "cleared");
    // a flag not yet seen survives a data read
    rxw(9'h003, 3'b001);
    rd(S_DA, 8'h03, "data two");
    rd(S_ST, 8'h2F, "frame kept");
    rd(S_DA, 8'h00, "");
    rd(S_ST, 8'h0B, "frame gone");
    // the fifth word overruns, its noise unflagged; later words are dropped
    for (int k = 0; k < 5; k++) rxw(9'h003, k == 4 ? 3'b010 : 3'b000);
    rd(S_DA, 8'h03, "data three");
    rxw(9'h055, 3'b000);
    rd(S_ST, 8'h1F, "overrun");
    // every data read consumes the arming, so a status read re-arms the avail clear
    for (int k = 0; k < 3; k++) begin
      rd(S_DA, 8'h03, "drain");
      rd(S_ST, 8'h00, "");
    end
    rd(S_ST, 8'h0B, "drained");
    // a low clock enable ignores an errored word
    CE = 1'b0;
    rxw(9'h0AA, 3'b011);
    CE = 1'b1;
    rd(S_ST, 8'h0B, "frozen");
    // nine-bit odd parity: three ones in all is correct; ninth bit reads back
    wr(S_C1, 8'hF1);
    rxw(9'h101, 3'b100);
    rd(S_C1, 8'hF2, "rx ninth");
    rd(S_ST, 8'h0F, "odd parity ok");
    rd(S_DA, 8'h01, "nine data");
    wr(S_C1, 8'hA1);
    pulse(1'b1);
    rd(S_ST, 8'h03, "rx busy");
    pulse(1'b0);
    rd(S_ST, 8'h0B, "rx idle");
    // transmit: flags drop on the write, empty returns on take, idle after the frame
    wr(S_DA, 8'h5A);
    rd(S_ST, 8'h08, "tx queued");
    wait_busy(1'b1);
    rd(S_ST, 8'h09, "tx taken");
    chk("tx word", 8'h5A, got[7:0]);
    chk("tx ninth", 8'h01, {7'h00, got[8]});
    wait_busy(1'b0);
    tick();
    rd(S_ST, 8'h0B, "tx idle");
    wr(S_C1, 8'hA4);
    rd(S_ST, 8'h09, "break");
    wr(S_C1, 8'hA0);
    rd(S_ST, 8'h0B, "break over");
    // port off with an errored word pending
    rxw(9'h001, 3'b011);
    wr(S_C1, 8'h20);
    rd(S_ST, 8'h0B, "port off");
    rd(S_C2, 8'h04, "ctrl two off");
    chk("ctrl two out", 8'h04, CTRL_TWO_OUT);
    chk("ctrl one out", 8'h20, CTRL_ONE_OUT);
    chk("int off", 8'h00, {7'h00, RX_INT_REQ});
    wrap_up();
  end
endmodule
`default_nettype wire
